// ==== ssc_defs.svh ====
// constants for the supply-control serial register slave and its master end
// assumes a 100 MHz core clock shared by both ends of the link
`ifndef SSC_DEFS_SVH
`define SSC_DEFS_SVH

// ************************************************************
// clock and timing
// ************************************************************
`define SSC_CLK_HZ          100000000
`define SSC_TONE_HZ         22000
`define SSC_TONE_HALF_CYC   (`SSC_CLK_HZ / (2 * `SSC_TONE_HZ))
`define SSC_TONE_HOLD_CYC   (4 * `SSC_TONE_HALF_CYC)
`define SSC_SCL_QTR_CYC     25

// ************************************************************
// bus address and bits per byte
// ************************************************************
`define SSC_BASE_ADDR       7'h08
`define SSC_BYTE_BITS       4'h8

// ************************************************************
// system_control_status fields
// ************************************************************
`define SSC_F_PULSED        7
`define SSC_F_CURLIM        6
`define SSC_F_TONE_EN       5
`define SSC_F_BOOST         4
`define SSC_F_VHIGH         3
`define SSC_F_OUT_EN        2
`define SSC_F_THERMAL       1
`define SSC_F_OVERLOAD      0
`define SSC_SCS_RESET       8'h00

// ************************************************************
// master command port map
// ************************************************************
`define SSC_HR_DATA         4'h0
`define SSC_HR_CTRL         4'h4
`define SSC_HR_STAT         4'h8
`define SSC_HC_GO           0
`define SSC_HC_READ         1
`define SSC_HC_SEL_LO       2
`define SSC_HC_SKIP_ACK     4

`endif

// ==== ssc_pkg.sv ====
// types shared by both ends of the supply-control serial link
// assumes ssc_defs.svh holds the numeric constants
package ssc_pkg;

  // device protocol states
  typedef enum logic [7:0] {
    DS_IDLE     = 8'h01,
    DS_ADDR     = 8'h02,
    DS_ADDR_ACK = 8'h04,
    DS_WR_DATA  = 8'h08,
    DS_WR_ACK   = 8'h10,
    DS_RD_DATA  = 8'h20,
    DS_RD_ACK   = 8'h40,
    DS_IGNORE   = 8'h80
  } ssc_dev_state_type;

  // master sequencer states
  typedef enum logic [3:0] {
    HS_IDLE  = 4'h1,
    HS_START = 4'h2,
    HS_BIT   = 4'h4,
    HS_STOP  = 4'h8
  } ssc_host_state_type;

endpackage : ssc_pkg

// ==== ssc_if.sv ====
// two-wire link between the master end and the register slave
// assumes both data drivers are open drain with an external pull-up
interface ssc_if;
  logic scl;
  logic sda;
  logic host_sda_o;
  logic host_sda_oe_n;
  logic dev_sda_o;
  logic dev_sda_oe_n;

  // wired-and of both open-drain drivers with a pull-up
  assign sda = !((!host_sda_oe_n && !host_sda_o) || (!dev_sda_oe_n && !dev_sda_o));

  modport device(input scl, input sda, output dev_sda_o, output dev_sda_oe_n);
  modport host(output scl, input sda, output host_sda_o, output host_sda_oe_n);
endinterface : ssc_if

// ==== ssc_sync.sv ====
// two-stage synchroniser with edge flags taken from the settled stage
// assumes inputs are asynchronous to core_clk
module ssc_sync #(
  parameter int W = 1
) (
  input  wire logic         core_clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] level,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);
  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;
  logic [W-1:0] prev_r;

  // meta stage is read only by the second stage
  always_ff @(posedge core_clk) begin
    if (rst) begin
      meta_r <= '0;
      sync_r <= '0;
      prev_r <= '0;
    end else begin
      meta_r <= din;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign level = sync_r;
  assign rise  = sync_r & ~prev_r;
  assign fall  = ~sync_r & prev_r;
endmodule : ssc_sync

// ==== ssc_device.sv ====
// register slave of the antenna supply controller with tone keying and detect
// assumes the link master drives scl and never stretches; status pins are async
//
// Added by the designer: the placing of the registers and the plain strobed port.
`include "ssc_defs.svh"
module ssc_device
  import ssc_pkg::*;
#(
  parameter int TONE_HALF_CYC = `SSC_TONE_HALF_CYC,
  parameter int TONE_HOLD_CYC = `SSC_TONE_HOLD_CYC
) (
  input  wire logic       core_clk,
  input  wire logic       rst,
  ssc_if.device           link,
  input  wire logic [1:0] addr_sel,
  input  wire logic       supply_good,
  input  wire logic       tone_keying_input,
  input  wire logic       tone_sense_input,
  input  wire logic       thermal_status,
  input  wire logic       overload_status,
  output logic            pulsed_limit_select,
  output logic            current_limit_select,
  output logic            cable_drop_boost,
  output logic            voltage_high_select,
  output logic            output_enable,
  output logic            tone_out,
  output logic            tone_detect_output_o,
  output logic            tone_detect_output_oe_n,
  output logic            bypass_switch_close
);

  // ************************************************************
  // input synchronisation
  // ************************************************************
  logic [1:0] line_s;
  logic [1:0] line_rise;
  logic [1:0] line_fall;
  logic [6:0] pin_s;
  logic [6:0] pin_rise;

  ssc_sync #(.W(2)) u_line (
    .core_clk (core_clk),
    .rst      (rst),
    .din      ({link.scl, link.sda}),
    .level    (line_s),
    .rise     (line_rise),
    .fall     (line_fall)
  );

  ssc_sync #(.W(7)) u_pins (
    .core_clk (core_clk),
    .rst      (rst),
    .din      ({addr_sel, supply_good, tone_keying_input, tone_sense_input, thermal_status, overload_status}),
    .level    (pin_s),
    .rise     (pin_rise),
    .fall     ()
  );

  logic       scl_s;
  logic       sda_s;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_seen;
  logic       stop_seen;
  logic [1:0] sel_s;
  logic       good_s;
  logic       keying_s;
  logic       sense_rise;
  logic       thermal_s;
  logic       overload_s;

  assign scl_s      = line_s[1];
  assign sda_s      = line_s[0];
  assign scl_rise   = line_rise[1];
  assign scl_fall   = line_fall[1];
  // both lines share one synchroniser delay, so edges keep their order
  assign start_seen = scl_s && line_fall[0];
  assign stop_seen  = scl_s && line_rise[0];
  assign sel_s      = pin_s[6:5];
  assign good_s     = pin_s[4];
  assign keying_s   = pin_s[3];
  assign sense_rise = pin_rise[2];
  assign thermal_s  = pin_s[1];
  assign overload_s = pin_s[0];

  // ************************************************************
  // register contents
  // ************************************************************
  logic [5:0] ctrl_r;
  logic [7:0] reg_view;
  logic [6:0] own_addr;

  // flags are taken live so a read shows protection state at that moment
  assign reg_view = {ctrl_r, thermal_s, overload_s};
  // address select level picks one of four consecutive addresses
  assign own_addr = 7'(`SSC_BASE_ADDR + {5'h00, sel_s});

  // ************************************************************
  // protocol engine
  // ************************************************************
  ssc_dev_state_type state_r;
  logic [3:0]        bit_cnt_r;
  logic [7:0]        shift_r;
  logic [7:0]        tx_r;
  logic              rw_r;
  logic              ack_seen_r;
  logic              sda_oe_n_r;
  logic              wr_commit;

  assign wr_commit = scl_fall && (state_r == DS_WR_DATA) && (bit_cnt_r == `SSC_BYTE_BITS);

  // low supply holds the engine idle and released, so nothing is acknowledged
  always_ff @(posedge core_clk) begin
    if (rst || !good_s) begin
      state_r    <= DS_IDLE;
      bit_cnt_r  <= 4'h0;
      shift_r    <= 8'h00;
      tx_r       <= 8'hFF;
      rw_r       <= 1'b0;
      ack_seen_r <= 1'b0;
      sda_oe_n_r <= 1'b1;
    end else if (start_seen) begin
      state_r    <= DS_ADDR;
      bit_cnt_r  <= 4'h0;
      sda_oe_n_r <= 1'b1;
    end else if (stop_seen) begin
      state_r    <= DS_IDLE;
      sda_oe_n_r <= 1'b1;
    end else if (scl_rise) begin
      // data is sampled only while the clock is high
      if (state_r == DS_ADDR || state_r == DS_WR_DATA) begin
        shift_r   <= {shift_r[6:0], sda_s};
        bit_cnt_r <= bit_cnt_r + 4'h1;
      end else if (state_r == DS_RD_DATA) begin
        bit_cnt_r <= bit_cnt_r + 4'h1;
      end else if (state_r == DS_RD_ACK) begin
        ack_seen_r <= !sda_s;
      end
    end else if (scl_fall) begin
      // the data line is only changed just after the clock falls
      unique case (state_r)
        DS_ADDR: begin
          if (bit_cnt_r == `SSC_BYTE_BITS) begin
            if (shift_r[7:1] == own_addr) begin
              state_r    <= DS_ADDR_ACK;
              rw_r       <= shift_r[0];
              sda_oe_n_r <= 1'b0;
            end else begin
              state_r <= DS_IGNORE;
            end
          end
        end
        DS_ADDR_ACK: begin
          bit_cnt_r <= 4'h0;
          if (rw_r) begin
            state_r    <= DS_RD_DATA;
            sda_oe_n_r <= reg_view[7];
            tx_r       <= {reg_view[6:0], 1'b1};
          end else begin
            state_r    <= DS_WR_DATA;
            sda_oe_n_r <= 1'b1;
          end
        end
        DS_WR_DATA: begin
          if (bit_cnt_r == `SSC_BYTE_BITS) begin
            state_r    <= DS_WR_ACK;
            sda_oe_n_r <= 1'b0;
          end
        end
        DS_WR_ACK: begin
          // one data byte per transfer; extra bytes pass unacknowledged
          state_r    <= DS_IGNORE;
          sda_oe_n_r <= 1'b1;
        end
        DS_RD_DATA: begin
          if (bit_cnt_r == `SSC_BYTE_BITS) begin
            state_r    <= DS_RD_ACK;
            sda_oe_n_r <= 1'b1;
          end else begin
            sda_oe_n_r <= tx_r[7];
            tx_r       <= {tx_r[6:0], 1'b1};
          end
        end
        DS_RD_ACK: begin
          bit_cnt_r <= 4'h0;
          if (ack_seen_r) begin
            state_r    <= DS_RD_DATA;
            sda_oe_n_r <= reg_view[7];
            tx_r       <= {reg_view[6:0], 1'b1};
          end else begin
            state_r <= DS_IGNORE;
          end
        end
        DS_IDLE: begin
        end
        DS_IGNORE: begin
        end
      endcase
    end
  end

  assign link.dev_sda_o    = 1'b0;
  assign link.dev_sda_oe_n = sda_oe_n_r;

  // ************************************************************
  // control register
  // ************************************************************
  // cleared at reset and again whenever the supply drops out
  always_ff @(posedge core_clk) begin
    if (rst || !good_s) begin
      ctrl_r <= 6'(`SSC_SCS_RESET >> 2);
    end else if (wr_commit) begin
      ctrl_r <= shift_r[7:2];
    end
  end

  assign pulsed_limit_select  = ctrl_r[`SSC_F_PULSED - 2];
  assign current_limit_select = ctrl_r[`SSC_F_CURLIM - 2];
  assign cable_drop_boost     = ctrl_r[`SSC_F_BOOST - 2];
  assign voltage_high_select  = ctrl_r[`SSC_F_VHIGH - 2];
  assign output_enable        = ctrl_r[`SSC_F_OUT_EN - 2];

  // ************************************************************
  // bypass switch
  // ************************************************************
  logic bypass_r;

  // standby closes the loop-through so the other receiver powers the line
  always_ff @(posedge core_clk) begin
    if (rst) begin
      bypass_r <= 1'b1;
    end else begin
      bypass_r <= !ctrl_r[`SSC_F_OUT_EN - 2];
    end
  end

  assign bypass_switch_close = bypass_r;

  // ************************************************************
  // carrier generation and keying
  // ************************************************************
  logic [15:0] carrier_cnt_r;
  logic        carrier_r;
  logic        tone_r;

  // free-running carrier; keying only gates it, so bursts start at any phase
  always_ff @(posedge core_clk) begin
    if (rst) begin
      carrier_cnt_r <= 16'h0000;
      carrier_r     <= 1'b0;
    end else if (carrier_cnt_r == 16'(TONE_HALF_CYC - 1)) begin
      carrier_cnt_r <= 16'h0000;
      carrier_r     <= !carrier_r;
    end else begin
      carrier_cnt_r <= carrier_cnt_r + 16'h0001;
    end
  end

  // power blocks off means no tone whatever the other bits say
  always_ff @(posedge core_clk) begin
    if (rst) begin
      tone_r <= 1'b0;
    end else begin
      tone_r <= ctrl_r[`SSC_F_OUT_EN - 2] && carrier_r &&
                (ctrl_r[`SSC_F_TONE_EN - 2] || keying_s);
    end
  end

  assign tone_out = tone_r;

  // ************************************************************
  // tone detector
  // ************************************************************
  logic [15:0] hold_cnt_r;
  logic        detect_oe_n_r;

  // tone counts as present while sense edges keep coming within two periods
  always_ff @(posedge core_clk) begin
    if (rst) begin
      hold_cnt_r <= 16'h0000;
    end else if (sense_rise) begin
      hold_cnt_r <= 16'(TONE_HOLD_CYC);
    end else if (hold_cnt_r != 16'h0000) begin
      hold_cnt_r <= hold_cnt_r - 16'h0001;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      detect_oe_n_r <= 1'b1;
    end else begin
      detect_oe_n_r <= (hold_cnt_r == 16'h0000);
    end
  end

  assign tone_detect_output_o    = 1'b0;
  assign tone_detect_output_oe_n = detect_oe_n_r;

endmodule : ssc_device

// ==== ssc_host.sv ====
// link master: runs one register transfer per command from a local port
// assumes the slave never stretches the clock; scl is made by a divider
`include "ssc_defs.svh"
module ssc_host
  import ssc_pkg::*;
#(
  parameter int QTR_CYC = `SSC_SCL_QTR_CYC
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  ssc_if.host              link,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata
);

  // ************************************************************
  // command registers
  // ************************************************************
  logic [7:0] data_r;
  logic       rw_r;
  logic [1:0] sel_r;
  logic       skip_r;
  logic       go;
  ssc_host_state_type state_r;

  assign go = reg_wr && (reg_addr == `SSC_HR_CTRL) && reg_wdata[`SSC_HC_GO] && (state_r == HS_IDLE);

  // settings are frozen while a transfer runs
  always_ff @(posedge core_clk) begin
    if (rst) begin
      data_r <= 8'h00;
      rw_r   <= 1'b0;
      sel_r  <= 2'h0;
      skip_r <= 1'b0;
    end else if (state_r == HS_IDLE && reg_wr) begin
      if (reg_addr == `SSC_HR_DATA) begin
        data_r <= reg_wdata[7:0];
      end else if (reg_addr == `SSC_HR_CTRL) begin
        rw_r   <= reg_wdata[`SSC_HC_READ];
        sel_r  <= reg_wdata[`SSC_HC_SEL_LO +: 2];
        skip_r <= reg_wdata[`SSC_HC_SKIP_ACK];
      end
    end
  end

  // ************************************************************
  // line sequencer
  // ************************************************************
  logic       sda_s;
  logic [7:0] qcnt_r;
  logic [1:0] qph_r;
  logic       tick;
  logic [3:0] bit_cnt_r;
  logic       frame_r;
  logic       scl_r;
  logic       oe_n_r;
  logic       nack_r;
  logic [7:0] rx_r;
  logic [7:0] out_byte;
  logic       drive_bit;

  ssc_sync #(.W(1)) u_sda (
    .core_clk (core_clk),
    .rst      (rst),
    .din      (link.sda),
    .level    (sda_s),
    .rise     (),
    .fall     ()
  );

  assign tick      = (qcnt_r == 8'(QTR_CYC - 1));
  assign out_byte  = frame_r ? data_r : {7'(`SSC_BASE_ADDR + {5'h00, sel_r}), rw_r};
  // address always driven; data driven only on writes; ack slots released
  assign drive_bit = (bit_cnt_r < `SSC_BYTE_BITS) && (!frame_r || !rw_r);

  // quarter-period phases: 0,1 clock low (data moves in 0), 2,3 clock high
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_r   <= HS_IDLE;
      qcnt_r    <= 8'h00;
      qph_r     <= 2'h0;
      bit_cnt_r <= 4'h0;
      frame_r   <= 1'b0;
      scl_r     <= 1'b1;
      oe_n_r    <= 1'b1;
      nack_r    <= 1'b0;
      rx_r      <= 8'h00;
    end else if (go) begin
      state_r <= HS_START;
      qcnt_r  <= 8'h00;
      qph_r   <= 2'h0;
      nack_r  <= 1'b0;
    end else if (state_r != HS_IDLE) begin
      qcnt_r <= tick ? 8'h00 : qcnt_r + 8'h01;
      if (tick) begin
        qph_r <= qph_r + 2'h1;
        unique case (state_r)
          HS_START: begin
            if (qph_r == 2'h1) begin
              oe_n_r <= 1'b0;
            end else if (qph_r == 2'h3) begin
              scl_r     <= 1'b0;
              state_r   <= HS_BIT;
              bit_cnt_r <= 4'h0;
              frame_r   <= 1'b0;
            end
          end
          HS_BIT: begin
            if (qph_r == 2'h0) begin
              oe_n_r <= drive_bit ? out_byte[3'(7 - bit_cnt_r)] : 1'b1;
            end else if (qph_r == 2'h1) begin
              scl_r <= 1'b1;
            end else if (qph_r == 2'h3) begin
              scl_r <= 1'b0;
              if (bit_cnt_r != `SSC_BYTE_BITS) begin
                if (frame_r && rw_r) begin
                  rx_r <= {rx_r[6:0], sda_s};
                end
                bit_cnt_r <= bit_cnt_r + 4'h1;
              end else if ((!frame_r || !rw_r) && sda_s && !skip_r) begin
                nack_r  <= 1'b1;
                state_r <= HS_STOP;
              end else if (frame_r) begin
                state_r <= HS_STOP;
              end else begin
                frame_r   <= 1'b1;
                bit_cnt_r <= 4'h0;
              end
            end
          end
          HS_STOP: begin
            if (qph_r == 2'h0) begin
              oe_n_r <= 1'b0;
            end else if (qph_r == 2'h1) begin
              scl_r <= 1'b1;
            end else if (qph_r == 2'h2) begin
              oe_n_r <= 1'b1;
            end else begin
              // idle, and so a new start, only once the stop is out
              state_r <= HS_IDLE;
            end
          end
          HS_IDLE: begin
          end
        endcase
      end
    end
  end

  assign link.scl           = scl_r;
  assign link.host_sda_o    = 1'b0;
  assign link.host_sda_oe_n = oe_n_r;

  // ************************************************************
  // read port
  // ************************************************************
  always_ff @(posedge core_clk) begin
    if (rst || !reg_rd) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_addr == `SSC_HR_DATA) begin
      reg_rdata <= {24'h000000, data_r};
    end else if (reg_addr == `SSC_HR_CTRL) begin
      reg_rdata <= {27'h0000000, skip_r, sel_r, rw_r, 1'b0};
    end else if (reg_addr == `SSC_HR_STAT) begin
      reg_rdata <= {16'h0000, rx_r, 6'h00, nack_r, state_r != HS_IDLE};
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

endmodule : ssc_host

// ==== ssc_checker.sv ====
// link checker: timing of the two open-drain ends on the shared serial pair
// assumes both ends run on core_clk and are cleared by rst
module ssc_checker (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic scl,
  input wire logic sda,
  input wire logic host_sda_oe_n,
  input wire logic dev_sda_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // ************************************************************
  // frame tracking
  // ************************************************************
  logic       scl_d;
  logic       sda_d;
  logic [4:0] bit_cnt;
  logic       rw_r;

  // previous line levels, for edge detection in the helpers
  always_ff @(posedge core_clk) begin
    scl_d <= scl;
    sda_d <= sda;
  end

  // clock rises since the last start; a start restarts the count
  always_ff @(posedge core_clk) begin
    if (rst) begin
      bit_cnt <= 5'h00;
    end else if (scl && sda_d && !sda) begin
      bit_cnt <= 5'h00;
    end else if (scl && !scl_d) begin
      bit_cnt <= bit_cnt + 5'h01;
    end
  end

  // direction bit is the last bit of the address byte
  always_ff @(posedge core_clk) begin
    if (scl && !scl_d && bit_cnt == 5'h07) begin
      rw_r <= sda;
    end
  end

  // ************************************************************
  // properties
  // ************************************************************
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence start_s; $fell(sda) && scl; endsequence
  sequence stop_s; $rose(sda) && scl; endsequence
  sequence rise_s; $rose(scl); endsequence

  AST_DEV_STABLE: assert property (scl && $past(scl) |-> $stable(dev_sda_oe_n))
    else $error("slave moved data while clock high");
  AST_START_HOLD: assert property (start_s |-> (scl && !sda)[*8])
    else $error("start not held");
  AST_STOP_HOLD: assert property (stop_s |-> sda[*8])
    else $error("line not idle after stop");
  AST_ACK_HELD: assert property (rise_s ##0 !dev_sda_oe_n |-> !dev_sda_oe_n[*8])
    else $error("slave low level dropped in high phase");
  AST_DEV_SLOT: assert property (rise_s ##0 !dev_sda_oe_n |->
    bit_cnt == 5'h08 || bit_cnt == 5'h11 || (rw_r && bit_cnt > 5'h08 && bit_cnt < 5'h11))
    else $error("slave drove outside its slots");
  AST_HOST_ACK_FREE: assert property (rise_s ##0 (bit_cnt == 5'h08 || bit_cnt == 5'h11) |-> host_sda_oe_n)
    else $error("master held data in acknowledge slot");
  AST_HOST_READ_FREE: assert property (rise_s ##0 (rw_r && bit_cnt > 5'h08 && bit_cnt < 5'h11) |-> host_sda_oe_n)
    else $error("master drove during read byte");
  // the stop phase raises the clock once more before data rises
  AST_STOP_COUNT: assert property (stop_s |-> bit_cnt == 5'h0A || bit_cnt == 5'h13)
    else $error("stop after odd bit count");
endmodule : ssc_checker

// ==== sat_supply_i2c_control_tb.sv ====
// bench: link master and register slave joined by one link, driven from the command port
// assumes ssc_defs.svh, ssc_pkg, ssc_if and both ends are compiled first
`include "ssc_defs.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_mismatch++; $display("CHECK FAILED %0t got %h exp %h", $time, g, e); end end
module sat_supply_i2c_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ************************************************************
  // signals and instances
  // ************************************************************
  logic        core_clk, take_d, th, ol, det_o, det_oe_n, tone_out, bypass_switch_close;
  logic        pulsed_limit_select, current_limit_select, cable_drop_boost, voltage_high_select, output_enable;
  logic        rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, rd_chk = 1'b0, supply_good = 1'b1;
  logic        tone_keying_input = 1'b0, tone_sense_input = 1'b0, thermal_status = 1'b0, overload_status = 1'b0;
  logic [1:0]  addr_sel = 2'h0;
  logic [3:0]  reg_addr = 4'h0;
  logic [7:0]  d;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, v, e_v, m_v;
  logic [31:0] exp_q[$], mask_q[$];
  int          compares = 0, n_mismatch = 0, n;

  ssc_if lnk ();
  ssc_host #(.QTR_CYC(8)) i_ssc_host (.core_clk(core_clk), .rst(rst), .link(lnk), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  ssc_device #(.TONE_HALF_CYC(4), .TONE_HOLD_CYC(20)) i_ssc_device (.core_clk(core_clk), .rst(rst), .link(lnk),
    .addr_sel(addr_sel), .supply_good(supply_good), .tone_keying_input(tone_keying_input),
    .tone_sense_input(tone_sense_input), .thermal_status(thermal_status), .overload_status(overload_status),
    .pulsed_limit_select(pulsed_limit_select), .current_limit_select(current_limit_select),
    .cable_drop_boost(cable_drop_boost), .voltage_high_select(voltage_high_select), .output_enable(output_enable),
    .tone_out(tone_out), .tone_detect_output_o(det_o), .tone_detect_output_oe_n(det_oe_n),
    .bypass_switch_close(bypass_switch_close));
  ssc_checker i_ssc_checker (.core_clk(core_clk), .rst(rst), .scl(lnk.scl), .sda(lnk.sda),
    .host_sda_oe_n(lnk.host_sda_oe_n), .dev_sda_oe_n(lnk.dev_sda_oe_n));

  // ************************************************************
  // clock, scoreboard and bus tasks
  // ************************************************************
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // read data stands only in the cycle after the strobe, so mark it here
  always @(posedge core_clk) take_d <= reg_rd && rd_chk;
  always @(negedge core_clk) begin
    if (take_d && exp_q.size() > 0) begin
      e_v = exp_q.pop_front();
      m_v = mask_q.pop_front();
      `CHK(reg_rdata & m_v, e_v)
    end
  end
  task automatic wr(input logic [3:0] a, input logic [31:0] w);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= w;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic c);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    rd_chk <= c;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    rd_chk <= 1'b0;
    @(negedge core_clk);
    v = reg_rdata;
  endtask : rd
  // cmd is {skip ack, address select, read, go}; busy is polled with a bound
  task automatic xfer(input logic [7:0] w, input logic [4:0] cmd);
    int k;
    wr(`SSC_HR_DATA, {24'h000000, w});
    wr(`SSC_HR_CTRL, {27'h0000000, cmd});
    k = 0;
    do begin
      rd(`SSC_HR_STAT, 1'b0);
      k++;
    end while (v[0] !== 1'b0 && k < 400);
    // a transfer that never finishes ends the run as a failure
    if (v[0] !== 1'b0) begin
      n_mismatch++;
      close_out();
    end
  endtask : xfer
  task automatic expect_stat(input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e);
    mask_q.push_back(m);
    rd(`SSC_HR_STAT, 1'b1);
  endtask : expect_stat
  task automatic pins(input logic [7:0] w);
    @(negedge core_clk);
    `CHK({pulsed_limit_select, current_limit_select, cable_drop_boost, voltage_high_select, output_enable}, {w[7:6], w[4:2]})
    `CHK(bypass_switch_close, ~w[2])
  endtask : pins
  task automatic tone_cnt();
    logic p;
    n = 0;
    p = tone_out;
    repeat (40) begin
      @(negedge core_clk);
      if (tone_out !== p) n++;
      p = tone_out;
    end
  endtask : tone_cnt
  task automatic close_out();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : close_out

  // ************************************************************
  // scenarios
  // ************************************************************
  // a full run is about twelve transfers of under 1000 cycles each
  initial begin
    #400000;
    n_mismatch++;
    close_out();
  end
  initial begin
    d = 8'($urandom(32'h9DEF67D7));
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    repeat (4) @(posedge core_clk);
    pins(8'h00);
    `CHK({tone_out, det_oe_n}, 2'b01)
    // every address select level, a write then a read-back with live flags
    for (int s = 0; s < 4; s++) begin
      d = 8'($urandom);
      th = 1'($urandom);
      ol = 1'($urandom);
      @(posedge core_clk);
      addr_sel <= s[1:0];
      thermal_status <= th;
      overload_status <= ol;
      xfer(d, {1'b0, s[1:0], 2'b01});
      expect_stat(32'h0, 32'h3);
      pins(d);
      xfer(8'h00, {1'b0, s[1:0], 2'b11});
      expect_stat({16'h0, d[7:2], th, ol, 8'h00}, 32'hFF01);
    end
    xfer(~d, 5'b00001);
    expect_stat(32'h2, 32'h3);
    pins(d);
    xfer(8'h24, {1'b1, addr_sel, 2'b01});
    pins(8'h24);
    tone_cnt();
    `CHK(n > 0, 1'b1)
    xfer(8'h04, {1'b0, addr_sel, 2'b01});
    tone_cnt();
    `CHK(n, 0)
    @(posedge core_clk);
    tone_keying_input <= 1'b1;
    tone_cnt();
    `CHK(n > 0, 1'b1)
    repeat (10) begin
      @(posedge core_clk);
      tone_sense_input <= ~tone_sense_input;
      repeat (3) @(posedge core_clk);
    end
    @(negedge core_clk);
    `CHK({det_o, det_oe_n}, 2'b00)
    repeat (60) @(posedge core_clk);
    `CHK(det_oe_n, 1'b1)
    // supply drops below lockout: no acknowledge and the register is cleared
    supply_good <= 1'b0;
    repeat (8) @(posedge core_clk);
    xfer(8'hFC, {1'b0, addr_sel, 2'b01});
    expect_stat(32'h2, 32'h3);
    pins(8'h00);
    close_out();
  end
endmodule : sat_supply_i2c_control_tb
